// File: rtl/eiu_pkg.sv
package eiu_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  // ==========================================================================
  localparam logic [7:0] IDX_PC_FLAGS  = 8'h1b;
  localparam logic [7:0] IDX_EXT_FLAGS = 8'h1c;
  localparam logic [7:0] IDX_EXT_EN    = 8'h1d;
  localparam logic [7:0] IDX_SENSE     = 8'h20;
  localparam logic [7:0] IDX_GRP_EN    = 8'h21;
  localparam logic [7:0] IDX_MASK0     = 8'h6b;
  localparam logic [7:0] IDX_MASK1     = 8'h6c;
  localparam logic [7:0] IDX_MASK2     = 8'h6d;
  localparam logic [7:0] IDX_NONE      = 8'hff;

  // ==========================================================================
  // Field layout and sizes
  // ==========================================================================
  localparam int unsigned EXT_PINS   = 2;
  localparam int unsigned PC_PINS    = 24;
  localparam int unsigned GROUPS     = 3;
  localparam int unsigned GROUP_W    = 8;
  localparam int unsigned SENSE_W    = 2;
  localparam int unsigned VEC_EXT0   = 0;
  localparam int unsigned VEC_PC0    = 2;
  localparam int unsigned VECTORS    = 5;
  localparam int unsigned PC_HOLE    = 15;

  // ==========================================================================
  // Reset values and timing counts
  // ==========================================================================
  localparam logic [7:0] RST_REG      = 8'h00;
  localparam logic [1:0] WARM_CYCLES  = 2'h3;

  // Trigger selection of one external pin
  typedef enum logic [1:0] {
    SENSE_LOW  = 2'h0,
    SENSE_ANY  = 2'h1,
    SENSE_FALL = 2'h2,
    SENSE_RISE = 2'h3
  } eiu_sense_t;

  // Whole state of the unit
  typedef struct packed {
    logic [EXT_PINS-1:0]         ext_s1;
    logic [EXT_PINS-1:0]         ext_s2;
    logic [EXT_PINS-1:0]         ext_prev;
    logic [PC_PINS-1:0]          pc_s1;
    logic [PC_PINS-1:0]          pc_s2;
    logic [PC_PINS-1:0]          pc_prev;
    logic [1:0]                  warm;
    logic [EXT_PINS*SENSE_W-1:0] sense;
    logic [EXT_PINS-1:0]         ext_en;
    logic [EXT_PINS-1:0]         ext_flag;
    logic [GROUPS-1:0]           grp_en;
    logic [GROUPS-1:0]           grp_flag;
    logic [PC_PINS-1:0]          pc_mask;
    logic                        ph_valid;
    logic                        ph_write;
    logic [7:0]                  ph_idx;
    logic                        rd_wait;
    logic [7:0]                  rdata;
  } eiu_state_t;

endpackage

// File: rtl/eiu_top.sv
// What this block does
// RL1: Pin 1 sense: low, change, fall, rise
// RL2: Pin 0 uses the same sense encoding
// RL3: Pins sampled; pulses over one clock caught
// RL4: Source holds low level until instruction ends
// RL5: Request needs global flag and own enable
// RL6: Enable register: bit1 pin 1, bit0 pin 0
// RL7: Pin activity counts even when driven out
// RL8: Edge sets pin flag; vector when enabled
// RL9: Handler entry clears the pin flag
// RL10: Writing one clears flag, zero keeps it
// RL11: Level mode flag reads zero, level requests
// RL12: Group enables bits 2..0, own vectors
// RL13: Any enabled group input change requests
// RL14: Group change sets group flag bit
// RL15: Group flag cleared by handler or one
// RL16: Unused register bits read as zero
// RL17: Level and group sensing need no edges; here both use the hclk synchroniser, frozen while clk_en is low
// RL18: Input counts only with mask and group
// RL19: Two-stage synchroniser plus previous value
//
// Chosen here: the AHB-Lite slave port.
module eiu_top
  import eiu_pkg::*;
(
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                clk_en,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic [EXT_PINS-1:0] ext_irq_pin,
  input  wire logic [PC_PINS-1:0]  pin_change_input,
  input  wire logic                cpu_int_enable,
  input  wire logic [VECTORS-1:0]  vec_ack,
  output logic      [VECTORS-1:0]  vec_req
);

  // ==========================================================================
  // State
  // ==========================================================================
  eiu_state_t q;
  eiu_state_t d;

  logic                addr_take;
  logic                addr_hit;
  logic                wr_commit;
  logic                warm_ok;
  logic [EXT_PINS-1:0] ext_lvl;
  logic [EXT_PINS-1:0] ext_trig;
  logic [EXT_PINS-1:0] ext_w1c;
  logic [EXT_PINS-1:0] ext_ack;
  logic [PC_PINS-1:0]  pc_chg;
  logic [GROUPS-1:0]   grp_trig;
  logic [GROUPS-1:0]   grp_w1c;
  logic [GROUPS-1:0]   grp_ack;

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  // Only word-aligned addresses inside the low window are mapped
  assign addr_hit  = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
  assign addr_take = hsel & htrans[1] & hready;
  assign wr_commit = q.ph_valid & q.ph_write;

  // Reads stall one cycle so a write just before them is already visible
  assign hreadyout = clk_en & ~q.rd_wait;
  assign hresp     = 1'b0;
  assign hrdata    = {24'h000000, q.rdata};

  // Flag clears by software write of one, or by handler entry
  assign ext_w1c = (wr_commit && q.ph_idx == IDX_EXT_FLAGS) ? hwdata[EXT_PINS-1:0] : '0;  // see RL10
  assign grp_w1c = (wr_commit && q.ph_idx == IDX_PC_FLAGS) ? hwdata[GROUPS-1:0] : '0;  // see RL15
  assign ext_ack = vec_ack[VEC_EXT0 +: EXT_PINS];
  assign grp_ack = vec_ack[VEC_PC0 +: GROUPS];

  // ==========================================================================
  // Detection
  // ==========================================================================
  // Edges are ignored until the synchroniser and history hold real samples,
  // otherwise a pin high at reset would look like a rising edge
  assign warm_ok = (q.warm == WARM_CYCLES);

  // Per external pin: decode the two sense bits into a trigger
  genvar gi;
  generate
    for (gi = 0; gi < EXT_PINS; gi++) begin : g_ext
      logic       rise;
      logic       fall;
      eiu_sense_t mode;
      assign mode         = eiu_sense_t'(q.sense[gi*SENSE_W +: SENSE_W]);
      assign rise         = ~q.ext_prev[gi] & q.ext_s2[gi];
      assign fall         = q.ext_prev[gi] & ~q.ext_s2[gi];
      assign ext_lvl[gi]  = (mode == SENSE_LOW);
      assign ext_trig[gi] = warm_ok & ((mode == SENSE_ANY)  ? (rise | fall) :  // see RL1 see RL2 see RL3
                                       (mode == SENSE_FALL) ? fall :
                                       (mode == SENSE_RISE) ? rise : 1'b0);
    end
  endgenerate

  // Per group: any masked input toggle while the group is enabled
  assign pc_chg = (q.pc_s2 ^ q.pc_prev) & q.pc_mask & {PC_PINS{warm_ok}};  // see RL13 see RL18
  generate
    for (gi = 0; gi < GROUPS; gi++) begin : g_grp
      assign grp_trig[gi] = (|pc_chg[gi*GROUP_W +: GROUP_W]) & q.grp_en[gi];  // see RL18
    end
  endgenerate

  // ==========================================================================
  // Requests
  // ==========================================================================
  // Level mode bypasses the flag and follows the synchronised pin; the source
  // must hold it low until the core accepts the request
  assign vec_req[VEC_EXT0 +: EXT_PINS] = {EXT_PINS{cpu_int_enable}} & q.ext_en &  // see RL5 see RL8
                                         ((ext_lvl & ~q.ext_s2) | (~ext_lvl & q.ext_flag));  // see RL11 see RL4 see RL17
  assign vec_req[VEC_PC0 +: GROUPS]    = {GROUPS{cpu_int_enable}} & q.grp_en & q.grp_flag;  // see RL12

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    logic [7:0] rd_mux;
    rd_mux = RST_REG;
    d      = q;

    // Pins are read straight from the pads, whatever their direction
    d.ext_s1   = ext_irq_pin;  // see RL7 see RL19
    d.ext_s2   = q.ext_s1;
    d.ext_prev = q.ext_s2;
    d.pc_s1    = pin_change_input;
    d.pc_s2    = q.pc_s1;
    d.pc_prev  = q.pc_s2;
    if (!warm_ok) begin
      d.warm = q.warm + 2'h1;
    end

    // Set wins over clear; level mode keeps the flag at zero
    d.ext_flag = ~ext_lvl & (ext_trig | (q.ext_flag & ~(ext_w1c | ext_ack)));  // see RL8 see RL9 see RL11
    d.grp_flag = grp_trig | (q.grp_flag & ~(grp_w1c | grp_ack));  // see RL14 see RL15

    // Register writes in the data phase
    if (wr_commit) begin
      case (q.ph_idx)
        IDX_SENSE: begin
          d.sense = hwdata[EXT_PINS*SENSE_W-1:0];
        end
        IDX_EXT_EN: begin
          d.ext_en = hwdata[EXT_PINS-1:0];  // see RL6
        end
        IDX_GRP_EN: begin
          d.grp_en = hwdata[GROUPS-1:0];  // see RL12
        end
        IDX_MASK0: begin
          d.pc_mask[7:0] = hwdata[7:0];
        end
        IDX_MASK1: begin
          d.pc_mask[PC_HOLE-1:8] = hwdata[6:0];  // see RL16
        end
        IDX_MASK2: begin
          d.pc_mask[23:16] = hwdata[7:0];
        end
        default: begin
          d.ph_write = q.ph_write;
        end
      endcase
    end

    // Read mux, unused bits stay zero
    case (q.ph_idx)
      IDX_SENSE: begin
        rd_mux = {4'h0, q.sense};  // see RL16
      end
      IDX_EXT_EN: begin
        rd_mux = {6'h00, q.ext_en};
      end
      IDX_EXT_FLAGS: begin
        rd_mux = {6'h00, q.ext_flag & ~ext_lvl};  // see RL11
      end
      IDX_GRP_EN: begin
        rd_mux = {5'h00, q.grp_en};
      end
      IDX_PC_FLAGS: begin
        rd_mux = {5'h00, q.grp_flag};
      end
      IDX_MASK0: begin
        rd_mux = q.pc_mask[7:0];
      end
      IDX_MASK1: begin
        rd_mux = {1'b0, q.pc_mask[PC_HOLE-1:8]};
      end
      IDX_MASK2: begin
        rd_mux = q.pc_mask[23:16];
      end
      default: begin
        rd_mux = RST_REG;
      end
    endcase

    // Address and data phase tracking
    if (q.rd_wait) begin
      d.rd_wait = 1'b0;
      d.rdata   = rd_mux;
    end else if (hready) begin
      d.ph_valid = addr_take;
      d.ph_write = hwrite;
      d.ph_idx   = addr_hit ? haddr[9:2] : IDX_NONE;
      d.rd_wait  = addr_take & ~hwrite;
    end
  end

  // Clock enable freezes every bit of state, bus tracking included
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_ext1_fall_flag: assert property (  // see RL1
    @(posedge hclk) disable iff (!hresetn)
    clk_en && warm_ok && q.sense[3:2] == 2'h2 && q.ext_prev[1] && !q.ext_s2[1] |=> q.ext_flag[1])
    else $error("pin 1 falling edge did not set its flag");

  a_ext0_rise_flag: assert property (  // see RL2
    @(posedge hclk) disable iff (!hresetn)
    clk_en && warm_ok && q.sense[1:0] == 2'h3 && !q.ext_prev[0] && q.ext_s2[0] |=> q.ext_flag[0])
    else $error("pin 0 rising edge did not set its flag");

  a_sync_two_stage: assert property (  // see RL19
    @(posedge hclk) disable iff (!hresetn)
    warm_ok && $past(clk_en, 1) && $past(clk_en, 2) |-> q.ext_s2 == $past(ext_irq_pin, 2))
    else $error("external pin synchroniser delay is not two cycles");

  a_no_global_req: assert property (  // see RL5
    @(posedge hclk) disable iff (!hresetn)
    !cpu_int_enable |-> vec_req == '0)
    else $error("request raised while global flag clear");

  a_level_req: assert property (  // see RL11
    @(posedge hclk) disable iff (!hresetn)
    cpu_int_enable && q.ext_en[0] && q.sense[1:0] == 2'h0 && !q.ext_s2[0] |-> vec_req[0] && !q.ext_flag[0])
    else $error("low level on pin 0 did not request");

  a_level_flag_zero: assert property (  // see RL11
    @(posedge hclk) disable iff (!hresetn)
    clk_en && q.sense[3:2] == 2'h0 |=> !q.ext_flag[1])
    else $error("pin 1 flag set in level mode");

  a_w1c_clear: assert property (  // see RL10
    @(posedge hclk) disable iff (!hresetn)
    clk_en && ext_w1c[0] && !ext_trig[0] |=> !q.ext_flag[0])
    else $error("writing one did not clear pin 0 flag");

  a_w0_keeps: assert property (  // see RL10
    @(posedge hclk) disable iff (!hresetn)
    clk_en && wr_commit && q.ph_idx == IDX_EXT_FLAGS && q.ext_flag[1] && !hwdata[1] && !ext_ack[1]
      && !ext_lvl[1] ##1 clk_en |-> q.ext_flag[1])
    else $error("writing zero changed pin 1 flag");

  a_ack_clear: assert property (  // see RL15
    @(posedge hclk) disable iff (!hresetn)
    clk_en && grp_ack[0] && !grp_trig[0] |=> !q.grp_flag[0])
    else $error("handler entry did not clear group 0 flag");

  a_grp_change: assert property (  // see RL13
    @(posedge hclk) disable iff (!hresetn)
    clk_en && q.grp_en[2] && |pc_chg[23:16] |=> q.grp_flag[2] ##0 (vec_req[4] == cpu_int_enable))
    else $error("group 2 change did not set flag and request");

  a_read_stall: assert property (  // see RL16
    @(posedge hclk) disable iff (!hresetn)
    addr_take && !hwrite && clk_en ##1 clk_en |=> hreadyout && hrdata[31:8] == 24'h000000)
    else $error("read did not complete after one wait cycle");

  a_ext1_rise_flag: assert property (  // see RL1
    @(posedge hclk) disable iff (!hresetn)
    clk_en && warm_ok && q.sense[3:2] == 2'h3 && !q.ext_prev[1] && q.ext_s2[1] |=> q.ext_flag[1])
    else $error("pin 1 rising edge did not set its flag");

  a_ext1_any_flag: assert property (  // see RL1
    @(posedge hclk) disable iff (!hresetn)
    clk_en && warm_ok && q.sense[3:2] == 2'h1 && (q.ext_prev[1] != q.ext_s2[1]) |=> q.ext_flag[1])
    else $error("pin 1 change did not set its flag");

  a_ext0_fall_flag: assert property (  // see RL2
    @(posedge hclk) disable iff (!hresetn)
    clk_en && warm_ok && q.sense[1:0] == 2'h2 && q.ext_prev[0] && !q.ext_s2[0] |=> q.ext_flag[0])
    else $error("pin 0 falling edge did not set its flag");

  a_ext0_any_flag: assert property (  // see RL2
    @(posedge hclk) disable iff (!hresetn)
    clk_en && warm_ok && q.sense[1:0] == 2'h1 && (q.ext_prev[0] != q.ext_s2[0]) |=> q.ext_flag[0])
    else $error("pin 0 change did not set its flag");

  a_trig_sets_flag: assert property (  // see RL8
    @(posedge hclk) disable iff (!hresetn)
    clk_en && ext_trig[0] |=> q.ext_flag[0])
    else $error("pin 0 trigger lost against a clear");

  a_ext_req_gate: assert property (  // see RL5
    @(posedge hclk) disable iff (!hresetn)
    (vec_req[1:0] & ~q.ext_en) == 2'h0)
    else $error("pin request raised while its enable is clear");

  a_reset_clear: assert property (  // see RL6
    @(posedge hclk)
    !hresetn |=> q.ext_en == 2'h0 && q.ext_flag == 2'h0 && q.pc_mask == 24'h000000)
    else $error("enables, flags or masks not zero after reset");

  a_ext_ack_clear: assert property (  // see RL9
    @(posedge hclk) disable iff (!hresetn)
    clk_en && ext_ack[1] && !ext_trig[1] |=> !q.ext_flag[1])
    else $error("handler entry did not clear pin 1 flag");

  a_grp_w1c_clear: assert property (  // see RL15
    @(posedge hclk) disable iff (!hresetn)
    clk_en && grp_w1c[1] && !grp_trig[1] |=> !q.grp_flag[1])
    else $error("writing one did not clear group 1 flag");

  a_grp_off_quiet: assert property (  // see RL18
    @(posedge hclk) disable iff (!hresetn)
    clk_en && !q.grp_en[0] && !q.grp_flag[0] |=> !q.grp_flag[0])
    else $error("group 0 flag set while group disabled");

  a_mask_off_quiet: assert property (  // see RL18
    @(posedge hclk) disable iff (!hresetn)
    clk_en && q.pc_mask[14:8] == 7'h00 && !q.grp_flag[1] |=> !q.grp_flag[1])
    else $error("group 1 flag set with every input masked");

  a_grp1_change: assert property (  // see RL14
    @(posedge hclk) disable iff (!hresetn)
    clk_en && q.grp_en[1] && |pc_chg[14:8] |=> q.grp_flag[1])
    else $error("group 1 change did not set its flag");

  a_grp0_change: assert property (  // see RL14
    @(posedge hclk) disable iff (!hresetn)
    clk_en && q.grp_en[0] && |pc_chg[7:0] |=> q.grp_flag[0])
    else $error("group 0 change did not set its flag");

  a_sense_unused: assert property (  // see RL16
    @(posedge hclk) disable iff (!hresetn)
    clk_en && q.rd_wait && q.ph_idx == IDX_SENSE |=> hrdata[7:4] == 4'h0)
    else $error("unused sense control bits read as one");

  a_flag_unused: assert property (  // see RL16
    @(posedge hclk) disable iff (!hresetn)
    clk_en && q.rd_wait && q.ph_idx == IDX_EXT_FLAGS |=> hrdata[7:2] == 6'h00)
    else $error("unused pin flag bits read as one");

endmodule

// File: testbench/eiu_core_model.sv
// ==========================================================
// Core acceptance side: takes one vector at a time
// ==========================================================
module eiu_core_model
  import eiu_pkg::*;
(
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               ack_en,
  input  wire logic [VECTORS-1:0] vec_req,
  output logic      [VECTORS-1:0] vec_ack
);
  timeunit 1ns;
  timeprecision 1ps;

  // Lowest pending vector wins; a gap cycle lets the flag drop first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vec_ack <= '0;
    end else if (ack_en && vec_req != '0 && vec_ack == '0) begin
      vec_ack <= vec_req & (~vec_req + VECTORS'(1));
    end else begin
      vec_ack <= '0;
    end
  end
endmodule

// File: testbench/test_external_pin_interrupt_unit.sv
module test_external_pin_interrupt_unit import eiu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic                hclk, hresetn, hwrite, hreadyout, hresp;
  logic                cpu_int_enable, ack_en, clk_en;
  logic [31:0]         haddr, hwdata, hrdata, rdv;
  logic [1:0]          htrans, exf, exr;
  logic [2:0]          hsize;
  logic [EXT_PINS-1:0] ext_irq_pin;
  logic [PC_PINS-1:0]  pin_change_input;
  logic [VECTORS-1:0]  vec_req, vec_ack;
  int                  err_count, check_count;
  logic [7:0] idx_tab [9] = '{IDX_PC_FLAGS, IDX_EXT_FLAGS, IDX_EXT_EN, IDX_SENSE,
                              IDX_GRP_EN, IDX_MASK0, IDX_MASK1, IDX_MASK2, IDX_NONE};
  logic [7:0] rb_tab [9]  = '{8'h00, 8'h00, 8'h03, 8'h0f, 8'h07, 8'hff, 8'h7f, 8'hff, 8'h00};
  int         pc_pin [5]  = '{0, 3, 8, 15, 23};
  logic [2:0] pc_exp [5]  = '{3'h0, 3'h1, 3'h2, 3'h0, 3'h4};

  // ==========================================================
  // Clock, design and core model
  // ==========================================================
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  eiu_top i_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ext_irq_pin(ext_irq_pin), .pin_change_input(pin_change_input),
    .cpu_int_enable(cpu_int_enable), .vec_ack(vec_ack), .vec_req(vec_req));

  eiu_core_model i_core (.hclk(hclk), .hresetn(hresetn), .ack_en(ack_en),
    .vec_req(vec_req), .vec_ack(vec_ack));

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One single word transfer; waits on the slave, never on a fixed count
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge hclk);
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check($sformatf("register %h", idx), rdv, {24'h0, exp});
  endtask

  // Pins held eight cycles, well past the synchroniser and one clock
  task automatic drive(input logic [1:0] e, input logic [23:0] p, input logic g);
    @(posedge hclk);
    ext_irq_pin <= e;
    pin_change_input <= p;
    cpu_int_enable <= g;
    repeat (8) @(posedge hclk);
    #1;
  endtask

  task automatic finish_test();
    if (err_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    finish_test();
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    hresetn = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    ext_irq_pin = 2'h3;
    pin_change_input = '0;
    cpu_int_enable = 1'b0;
    ack_en = 1'b0;
    clk_en = 1'b1;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    foreach (idx_tab[i]) rd(idx_tab[i], 8'h00);
    foreach (idx_tab[i]) begin
      bus(1'b1, idx_tab[i], 8'hff);
      rd(idx_tab[i], rb_tab[i]);
    end
    // Idle pins high so the level-mode pin never requests
    drive(2'h3, 24'h0, 1'b1);
    for (int p = 0; p < 2; p++) begin
      for (int m = 1; m < 4; m++) begin
        bus(1'b1, IDX_SENSE, 8'(m << (2 * p)));
        exf = (m != 3) ? 2'(1 << p) : 2'h0;
        exr = (m != 2) ? 2'(1 << p) : 2'h0;
        drive(2'(~(1 << p)), 24'h0, 1'b1);
        check("vec_req", {27'h0, vec_req}, {30'h0, exf});
        rd(IDX_EXT_FLAGS, {6'h0, exf});
        bus(1'b1, IDX_EXT_FLAGS, 8'h00);
        rd(IDX_EXT_FLAGS, {6'h0, exf});
        bus(1'b1, IDX_EXT_FLAGS, 8'h03);
        drive(2'h3, 24'h0, 1'b1);
        rd(IDX_EXT_FLAGS, {6'h0, exr});
        bus(1'b1, IDX_EXT_FLAGS, 8'h03);
        rd(IDX_EXT_FLAGS, 8'h00);
      end
    end
    // Level mode: request follows the held low level, flag stays clear
    bus(1'b1, IDX_SENSE, 8'h00);
    drive(2'h2, 24'h0, 1'b1);
    check("vec_req", {27'h0, vec_req}, 32'h1);
    rd(IDX_EXT_FLAGS, 8'h00);
    drive(2'h2, 24'h0, 1'b0);
    check("vec_req", {27'h0, vec_req}, 32'h0);
    bus(1'b1, IDX_EXT_EN, 8'h00);
    drive(2'h2, 24'h0, 1'b1);
    check("vec_req", {27'h0, vec_req}, 32'h0);
    drive(2'h3, 24'h0, 1'b1);
    bus(1'b1, IDX_EXT_EN, 8'h03);
    // Handler entry through the core model clears a falling-edge flag
    bus(1'b1, IDX_SENSE, 8'h02);
    @(posedge hclk) ack_en <= 1'b1;
    drive(2'h2, 24'h0, 1'b1);
    rd(IDX_EXT_FLAGS, 8'h00);
    check("vec_req", {27'h0, vec_req}, 32'h0);
    @(posedge hclk) ack_en <= 1'b0;
    drive(2'h3, 24'h0, 1'b1);
    // Clock enable low freezes detection and stalls the bus; the edge shows once it runs again
    @(posedge hclk) clk_en <= 1'b0;
    drive(2'h2, 24'h0, 1'b1);
    check("hreadyout", {31'h0, hreadyout}, 32'h0);
    check("vec_req", {27'h0, vec_req}, 32'h0);
    @(posedge hclk) clk_en <= 1'b1;
    drive(2'h2, 24'h0, 1'b1);
    check("vec_req", {27'h0, vec_req}, 32'h1);
    bus(1'b1, IDX_EXT_FLAGS, 8'h03);
    drive(2'h3, 24'h0, 1'b1);
    // Pin-change groups; pin 0 masked, pin 15 in group 1 but with no writable mask bit
    bus(1'b1, IDX_MASK0, 8'h08);
    foreach (pc_pin[i]) begin
      drive(2'h3, 24'h1 << pc_pin[i], 1'b1);
      check("vec_req", {27'h0, vec_req}, {27'h0, pc_exp[i], 2'h0});
      rd(IDX_PC_FLAGS, {5'h0, pc_exp[i]});
      bus(1'b1, IDX_PC_FLAGS, 8'h07);
      rd(IDX_PC_FLAGS, 8'h00);
      drive(2'h3, 24'h0, 1'b1);
      bus(1'b1, IDX_PC_FLAGS, 8'h07);
    end
    bus(1'b1, IDX_GRP_EN, 8'h00);
    drive(2'h3, 24'h8, 1'b1);
    rd(IDX_PC_FLAGS, 8'h00);
    finish_test();
  end
endmodule
